// ==== design/fwsr_host.sv ====
// Host controller issuing command sequences to a parallel flash and polling status
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ns
module fwsr_host (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    // Flash pins
    output logic             o_flash_ce_n,
    output logic             o_flash_we_n,
    output logic             o_flash_oe_n,
    output logic [20:0]      o_flash_addr,
    output logic [15:0]      o_flash_dq_out,
    output logic             o_flash_dq_oe,
    input  wire logic [15:0] i_flash_dq_in,
    input  wire logic        i_ready_busy_n
);
    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_ACT    = 3'b010,
        ST_SAMPLE = 3'b011,
        ST_END    = 3'b100
    } fwsr_state_type;
    typedef enum logic [1:0] {
        PH_SEQ     = 2'b00,
        PH_POLL    = 2'b01,
        PH_FINAL   = 2'b10,
        PH_RECOVER = 2'b11
    } fwsr_phase_type;

    // ==========================================================
    // One bus cycle of a sequence: {read, last, address, data}
    function automatic logic [38:0] step_of(input logic [3:0] op, input logic [2:0] i,
                                            input logic [20:0] a, input logic [15:0] d);
        logic [20:0] sa;
        logic [15:0] sd;
        logic        rd;
        logic        last;
        sa   = fwsr_pkg::UNLOCK1_ADDR;
        sd   = fwsr_pkg::D_UNLOCK1;
        rd   = 1'b0;
        last = 1'b0;
        if (i == 3'd1 || i == 3'd4) begin
            sa = fwsr_pkg::UNLOCK2_ADDR;
            sd = fwsr_pkg::D_UNLOCK2;
        end
        case (op)
            fwsr_pkg::OP_READ: begin
                sa = a; rd = 1'b1; last = 1'b1;
            end
            fwsr_pkg::OP_RESET: begin
                sd = fwsr_pkg::D_RESET; last = 1'b1;
            end
            fwsr_pkg::OP_AUTOSEL: begin
                if (i == 3'd2) sd = fwsr_pkg::D_AUTOSEL;
                else if (i == 3'd3) begin
                    sa = a; rd = 1'b1; last = 1'b1;
                end
            end
            fwsr_pkg::OP_PROGRAM: begin
                if (i == 3'd2) sd = fwsr_pkg::D_PROG;
                else if (i == 3'd3) begin
                    sa = a; sd = d; last = 1'b1;
                end
            end
            fwsr_pkg::OP_BYP_ENTER: begin
                if (i == 3'd2) begin
                    sd = fwsr_pkg::D_BYPASS; last = 1'b1;
                end
            end
            fwsr_pkg::OP_BYP_PROG: begin
                if (i == 3'd0) sd = fwsr_pkg::D_PROG;
                else begin
                    sa = a; sd = d; last = 1'b1;
                end
            end
            fwsr_pkg::OP_BYP_RESET: begin
                if (i == 3'd0) sd = fwsr_pkg::D_AUTOSEL;
                else begin
                    sd = fwsr_pkg::D_BYP_EXIT; last = 1'b1;
                end
            end
            fwsr_pkg::OP_CHIP_ERASE, fwsr_pkg::OP_SECT_ERASE: begin
                if (i == 3'd2) sd = fwsr_pkg::D_ERASE;
                else if (i == 3'd5) begin
                    last = 1'b1;
                    if (op == fwsr_pkg::OP_SECT_ERASE) begin
                        sa = a; sd = fwsr_pkg::D_SECT;
                    end else sd = fwsr_pkg::D_CHIP;
                end
            end
            fwsr_pkg::OP_SUSPEND: begin
                sa = a; sd = fwsr_pkg::D_SUSPEND; last = 1'b1;
            end
            fwsr_pkg::OP_RESUME: begin
                sa = a; sd = fwsr_pkg::D_RESUME; last = 1'b1;
            end
            fwsr_pkg::OP_CFI: begin
                sa = fwsr_pkg::CFI_ADDR; sd = fwsr_pkg::D_CFI; last = 1'b1;
            end
            default: last = 1'b1;
        endcase
        return {rd, last, sa, sd};
    endfunction

    // ==========================================================
    // State
    fwsr_state_type state_r;
    fwsr_phase_type phase_r;
    logic [3:0]  op_r;
    logic [2:0]  idx_r;
    logic [20:0] addr_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    logic        busy_r, done_r, fail_r, refused_r;
    logic        bypass_r, autosel_r, rb_r;
    logic        first_r, prev_tog_r;
    logic [1:0]  late_r;
    logic        pready_r, pslverr_r;
    logic [31:0] prdata_r;

    // ==========================================================
    // Decode
    wire        apb_setup  = i_psel & ~i_penable;
    wire        apb_access = i_psel & i_penable & pready_r;
    wire        apb_wr     = apb_access & i_pwrite & ~pslverr_r;
    wire        mapped     = (i_paddr == fwsr_pkg::REG_CMD) | (i_paddr == fwsr_pkg::REG_ADDR) |
                             (i_paddr == fwsr_pkg::REG_WDATA) |
                             (i_paddr == fwsr_pkg::REG_STATUS) |
                             (i_paddr == fwsr_pkg::REG_RDATA);
    wire [3:0]  new_op     = i_pwdata[3:0];
    wire        cmd_wr     = apb_wr & (i_paddr == fwsr_pkg::REG_CMD) & ~busy_r;
    // Host-side legality: bypass program only inside bypass, and in autoselect
    // only read, reset or query make sense until a reset is issued
    wire        op_bad     = (new_op > fwsr_pkg::OP_CFI) |
                             ((new_op == fwsr_pkg::OP_BYP_PROG) & ~bypass_r) |
                             (bypass_r & (new_op == fwsr_pkg::OP_PROGRAM)) |
                             (autosel_r & (new_op != fwsr_pkg::OP_RESET) &
                              (new_op != fwsr_pkg::OP_READ) & (new_op != fwsr_pkg::OP_CFI));
    wire        start      = cmd_wr & ~op_bad;
    wire [38:0] step       = step_of(op_r, idx_r, addr_r, wdata_r);
    wire        seq_ph     = (phase_r == PH_SEQ);
    wire        rec_ph     = (phase_r == PH_RECOVER);
    wire        cur_rd     = seq_ph ? step[38] : ~rec_ph;
    wire        cur_last   = step[37];
    wire [20:0] cur_addr   = seq_ph ? step[36:16] :
                             (rec_ph ? fwsr_pkg::UNLOCK1_ADDR : addr_r);
    wire [15:0] cur_data   = seq_ph ? step[15:0] : fwsr_pkg::D_RESET;
    wire        polled     = (op_r == fwsr_pkg::OP_PROGRAM) | (op_r == fwsr_pkg::OP_BYP_PROG) |
                             (op_r == fwsr_pkg::OP_CHIP_ERASE) |
                             (op_r == fwsr_pkg::OP_SECT_ERASE);
    wire        toggling   = rdata_r[fwsr_pkg::DQ_TOGGLE1] ^ prev_tog_r;
    wire        timed_out  = rdata_r[fwsr_pkg::DQ_TIMEOUT];
    wire [31:0] status_w   = {25'h0, rb_r, autosel_r, bypass_r, refused_r, fail_r, done_r,
                              busy_r};
    wire [31:0] rd_mux     = (i_paddr == fwsr_pkg::REG_ADDR)   ? {11'h0, addr_r} :
                             (i_paddr == fwsr_pkg::REG_WDATA)  ? {16'h0, wdata_r} :
                             (i_paddr == fwsr_pkg::REG_STATUS) ? status_w :
                             (i_paddr == fwsr_pkg::REG_RDATA)  ? {16'h0, rdata_r} :
                             {28'h0, op_r};

    // ==========================================================
    // APB slave: answers in the first access cycle
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
            addr_r    <= 21'h0;
            wdata_r   <= 16'h0;
            rb_r      <= 1'b1;
        end else begin
            pready_r  <= apb_setup;
            pslverr_r <= apb_setup & ~mapped;
            rb_r      <= i_ready_busy_n;
            if (apb_setup) prdata_r <= mapped ? rd_mux : 32'h0;
            if (apb_wr && i_paddr == fwsr_pkg::REG_ADDR && !busy_r) addr_r <= i_pwdata[20:0];
            if (apb_wr && i_paddr == fwsr_pkg::REG_WDATA && !busy_r) wdata_r <= i_pwdata[15:0];
        end
    end

    // ==========================================================
    // Bus cycle engine: setup, strobe low one cycle, release, end
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r <= ST_IDLE;  phase_r <= PH_SEQ;   op_r <= 4'h0;   idx_r <= 3'h0;
            busy_r <= 1'b0;      done_r <= 1'b0;      fail_r <= 1'b0; refused_r <= 1'b0;
            bypass_r <= 1'b0;    autosel_r <= 1'b0;   first_r <= 1'b0;
            prev_tog_r <= 1'b0;  late_r <= 2'h0;      rdata_r <= 16'h0;
            o_flash_ce_n <= 1'b1; o_flash_we_n <= 1'b1; o_flash_oe_n <= 1'b1;
            o_flash_addr <= 21'h0; o_flash_dq_out <= 16'h0; o_flash_dq_oe <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmd_wr) refused_r <= op_bad;
                    if (start) begin
                        op_r <= new_op;  idx_r <= 3'h0;   phase_r <= PH_SEQ;
                        busy_r <= 1'b1;  done_r <= 1'b0;  fail_r <= 1'b0;
                        late_r <= 2'h0;  state_r <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    o_flash_addr   <= cur_addr;
                    o_flash_dq_out <= cur_data;
                    o_flash_dq_oe  <= ~cur_rd;
                    state_r        <= ST_ACT;
                end
                ST_ACT: begin
                    o_flash_ce_n <= 1'b0;
                    o_flash_we_n <= cur_rd;
                    o_flash_oe_n <= ~cur_rd;
                    state_r      <= ST_SAMPLE;
                end
                ST_SAMPLE: begin
                    o_flash_ce_n <= 1'b1;
                    o_flash_we_n <= 1'b1;
                    o_flash_oe_n <= 1'b1;
                    if (cur_rd) rdata_r <= i_flash_dq_in;
                    state_r <= ST_END;
                end
                ST_END: begin
                    o_flash_dq_oe <= 1'b0;
                    state_r       <= ST_SETUP;
                    case (phase_r)
                        PH_SEQ: begin
                            if (!cur_last) idx_r <= idx_r + 3'h1;
                            else if (polled) begin
                                phase_r <= PH_POLL;
                                first_r <= 1'b1;
                            end else begin
                                state_r <= ST_IDLE; busy_r <= 1'b0; done_r <= 1'b1;
                                if (op_r == fwsr_pkg::OP_AUTOSEL) autosel_r <= 1'b1;
                                if (op_r == fwsr_pkg::OP_RESET) autosel_r <= 1'b0;
                                if (op_r == fwsr_pkg::OP_BYP_ENTER) bypass_r <= 1'b1;
                                if (op_r == fwsr_pkg::OP_BYP_RESET) bypass_r <= 1'b0;
                            end
                        end
                        PH_POLL: begin
                            first_r    <= 1'b0;
                            prev_tog_r <= rdata_r[fwsr_pkg::DQ_TOGGLE1];
                            // Toggle compare, not the polling bit, so a late
                            // settling of bit 7 cannot end the poll early
                            if (!first_r && !toggling) phase_r <= PH_FINAL;
                            else if (!first_r && timed_out) begin
                                late_r <= late_r + 2'h1;
                                if (late_r == fwsr_pkg::LATE_READS - 2'h1)
                                    phase_r <= PH_RECOVER;
                            end
                        end
                        PH_FINAL: begin
                            state_r <= ST_IDLE; busy_r <= 1'b0; done_r <= 1'b1;
                        end
                        default: begin
                            state_r <= ST_IDLE; busy_r <= 1'b0; fail_r <= 1'b1;
                            autosel_r <= 1'b0;
                        end
                    endcase
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    assign o_pready  = pready_r;
    assign o_prdata  = prdata_r;
    assign o_pslverr = pslverr_r;

    // ==========================================================
    // Checks
    sequence s_write_pulse;
        !o_flash_ce_n && !o_flash_we_n && o_flash_dq_oe ##1 o_flash_we_n && o_flash_dq_oe;
    endsequence
    sequence s_read_pulse;
        !o_flash_ce_n && !o_flash_oe_n && !o_flash_dq_oe ##1 o_flash_oe_n;
    endsequence

    a_write_cycle_shape: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $fell(o_flash_we_n) |-> s_write_pulse)
        else $error("write strobe without driven data");
    a_read_cycle_shape: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $fell(o_flash_oe_n) |-> o_flash_we_n and s_read_pulse)
        else $error("read strobe while driving or writing");
    a_plain_read_once: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (start && new_op == fwsr_pkg::OP_READ) |->
        o_flash_we_n [*5] ##1 (done_r && !busy_r))
        else $error("plain read not a single read cycle");
    a_recover_reset: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $rose(fail_r) |-> $past(o_flash_dq_out) == fwsr_pkg::D_RESET && $past(phase_r) == PH_RECOVER)
        else $error("failure without reset command");
    a_bypass_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (cmd_wr && new_op == fwsr_pkg::OP_BYP_PROG && !bypass_r) |=> refused_r && !busy_r)
        else $error("bypass program issued outside bypass mode");
    a_final_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
        ($rose(done_r) && polled) |-> $past(phase_r) == PH_FINAL && $past(o_flash_oe_n, 2) == 1'b0)
        else $error("poll finished without a further read");
    a_late_rechecks: assert property (@(posedge i_clock) disable iff (!i_resetn)
        $rose(fail_r) |-> late_r == fwsr_pkg::LATE_READS)
        else $error("failure declared before two rechecks");
    a_autosel_exit: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (autosel_r && start) |-> new_op inside {fwsr_pkg::OP_RESET, fwsr_pkg::OP_READ,
                                               fwsr_pkg::OP_CFI})
        else $error("command issued in autoselect without reset");
endmodule // fwsr_host

// ==== shared/fwsr_pkg.sv ====
// Constants and types for the flash write/status host controller
package fwsr_pkg;
    // ==========================================================
    // Widths
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    // ==========================================================
    // Own register map (APB byte offsets)
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;
    // Status register bit positions
    localparam int ST_BUSY    = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_FAIL    = 2;
    localparam int ST_REFUSED = 3;
    localparam int ST_BYPASS  = 4;
    localparam int ST_AUTOSEL = 5;
    localparam int ST_READY   = 6;
    // ==========================================================
    // Operations written to REG_CMD
    typedef enum logic [3:0] {
        OP_READ       = 4'h0,
        OP_RESET      = 4'h1,
        OP_AUTOSEL    = 4'h2,
        OP_PROGRAM    = 4'h3,
        OP_BYP_ENTER  = 4'h4,
        OP_BYP_PROG   = 4'h5,
        OP_BYP_RESET  = 4'h6,
        OP_CHIP_ERASE = 4'h7,
        OP_SECT_ERASE = 4'h8,
        OP_SUSPEND    = 4'h9,
        OP_RESUME     = 4'ha,
        OP_CFI        = 4'hb
    } fwsr_op_type;
    // ==========================================================
    // Command cycle addresses and data
    localparam logic [20:0] UNLOCK1_ADDR = 21'h000555;
    localparam logic [20:0] UNLOCK2_ADDR = 21'h0002aa;
    localparam logic [20:0] CFI_ADDR     = 21'h000055;
    localparam logic [15:0] D_UNLOCK1    = 16'h00aa;
    localparam logic [15:0] D_UNLOCK2    = 16'h0055;
    localparam logic [15:0] D_RESET      = 16'h00f0;
    localparam logic [15:0] D_AUTOSEL    = 16'h0090;
    localparam logic [15:0] D_PROG       = 16'h00a0;
    localparam logic [15:0] D_BYPASS     = 16'h0020;
    localparam logic [15:0] D_BYP_EXIT   = 16'h0000;
    localparam logic [15:0] D_ERASE      = 16'h0080;
    localparam logic [15:0] D_CHIP       = 16'h0010;
    localparam logic [15:0] D_SECT       = 16'h0030;
    localparam logic [15:0] D_SUSPEND    = 16'h00b0;
    localparam logic [15:0] D_RESUME     = 16'h0030;
    localparam logic [15:0] D_CFI        = 16'h0098;
    // ==========================================================
    // Status bits on the data pins and poll limits
    localparam int         DQ_TOGGLE1 = 6;
    localparam int         DQ_TIMEOUT = 5;
    localparam logic [1:0] LATE_READS = 2'd2;
endpackage

// ==== sim/fwsr_flash_model.sv ====
// Behavioural parallel flash that answers the host controller's bus cycles
`timescale 1ns/1ns
module fwsr_flash_model #(
    parameter int          BUSY_READS = 3,
    parameter logic [8:0]  PROT_SECT  = 9'h1ff,
    parameter logic        LOCKED     = 1'b1,
    // Arbitrary query answer
    parameter logic [15:0] CFI_WORD   = 16'h00c5
) (
    // Strobes and address
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic [20:0] i_addr,
    // Data and status
    input  wire logic [15:0] i_dq,
    input  wire logic        i_stuck,
    output logic [15:0]      o_dq,
    output logic             o_ready_busy_n
);
    // ==========================================================
    // Array and state; only 256 words kept to stay small
    logic [15:0] mem [256];
    logic [20:0] a_lat;
    logic [15:0] last;
    logic        pend, armed, t1, t2, erasing, susp, asel, cfi;
    int          busy, saved;
    wire         wr_act = !i_ce_n && !i_we_n;
    wire         rd_act = !i_ce_n && !i_oe_n;
    wire         dp     = erasing ? 1'b0 : ~mem[i_addr[7:0]][7];
    wire  [15:0] stat   = {8'h00, dp, t1, i_stuck, 1'b0, erasing, t2 & erasing, 2'h0};
    wire  [7:0]  asel_w = (i_addr[7:0] == 8'h03) ? {LOCKED, 7'h00} :
                          {7'h00, i_addr[20:12] == PROT_SECT};
    wire  [15:0] word   = (busy > 0) ? stat : asel ? {8'h00, asel_w} :
                          cfi ? CFI_WORD : mem[i_addr[7:0]];
    initial begin
        foreach (mem[i]) mem[i] = 16'hffff;
        {pend, armed, t1, t2, erasing, susp, asel, cfi, busy, saved, last} = '0;
    end
    // ==========================================================
    // Write cycles
    always @(posedge wr_act) a_lat = i_addr;
    // Only the low byte picks a word; bits 20:12 decide whether the sector is protected
    always @(negedge wr_act) begin
        if (pend) begin
            if (a_lat[20:12] != PROT_SECT) mem[a_lat[7:0]] = i_dq;
            pend = 1'b0;
            busy = BUSY_READS;
        end else if (i_dq[7:0] == 8'ha0) begin
            pend = 1'b1;
        end else if (i_dq[7:0] == 8'h80) begin
            armed = 1'b1;
        end else if (armed && (i_dq[7:0] == 8'h10 || i_dq[7:0] == 8'h30)) begin
            armed = 1'b0;
            erasing = 1'b1;
            busy = BUSY_READS;
        end else if (i_dq[7:0] == 8'hb0 && erasing && busy > 0) begin
            susp = 1'b1;
            saved = busy;
            busy = 0;
        end else if (susp && i_dq[7:0] == 8'h30) begin
            susp = 1'b0;
            busy = saved;
        end else if (i_dq[7:0] == 8'h90) begin
            asel = 1'b1;
        end else if (i_dq[7:0] == 8'h00) begin
            asel = 1'b0;
        end else if (i_dq[7:0] == 8'h98 && busy == 0) begin
            cfi = 1'b1;
        end else if (i_dq[7:0] == 8'hf0) begin
            busy = 0;
            erasing = 1'b0;
            asel = 1'b0;
            cfi = 1'b0;
        end
    end
    // ==========================================================
    // Read cycles; a released bus shows the inverse of the last word
    always @(negedge rd_act) begin
        last = word;
        if (busy > 0) t1 = ~t1;
        if (busy > 0) t2 = ~t2;
        if (busy > 0 && !i_stuck) busy--;
        if (busy == 0 && !susp) erasing = 1'b0;
    end
    assign o_dq = rd_act ? word : ~last;
    assign o_ready_busy_n = (busy == 0);
endmodule // fwsr_flash_model

// ==== sim/tb.sv ====
// Self-checking bench for the flash host controller
`timescale 1ns/1ns
module tb;
    logic        i_clock, i_resetn, i_psel, i_penable, i_pwrite, stuck, err, byp, aut, e;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, o_prdata, r;
    logic        o_pready, o_pslverr, ce_n, we_n, oe_n, dq_oe, rbn;
    logic [20:0] fa;
    logic [15:0] dq_out, fl_dq, dq_bus, wd;
    int          mismatches, compares, k;
    logic [3:0]  ops [14] = '{4'h2, 4'h3, 4'hb, 4'h1, 4'h4, 4'h3, 4'h5,
                              4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'h0, 4'hc};
    logic [20:0] fa_bus;
    assign dq_bus = dq_oe ? dq_out : fl_dq;
    fwsr_host u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
        .o_pslverr(o_pslverr), .o_flash_ce_n(ce_n), .o_flash_we_n(we_n),
        .o_flash_oe_n(oe_n), .o_flash_addr(fa_bus), .o_flash_dq_out(dq_out),
        .o_flash_dq_oe(dq_oe), .i_flash_dq_in(dq_bus), .i_ready_busy_n(rbn));
    fwsr_flash_model u_flash (.i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
        .i_addr(fa_bus), .i_dq(dq_bus), .i_stuck(stuck), .o_dq(fl_dq),
        .o_ready_busy_n(rbn));
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Requests change only after a rising edge; pready is read before the edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(negedge i_clock);
            if (o_pready === 1'b1) break;
        end
        if (k == 20) mismatches++;
        r = o_prdata;
        err = o_pslverr;
        @(posedge i_clock);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic run(input logic [3:0] op);
        apb(1'b1, fwsr_pkg::REG_CMD, 32'(op));
        for (int i = 0; i < 400; i++) begin
            apb(1'b0, fwsr_pkg::REG_STATUS, '0);
            if (r[fwsr_pkg::ST_BUSY] === 1'b0) break;
        end
    endtask
    function automatic logic refused(input logic [3:0] op);
        return op > 4'hb || (op == 4'h5 && !byp) || (op == 4'h3 && byp) ||
               (aut && !(op inside {4'h0, 4'h1, 4'hb}));
    endfunction
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Clock, watchdog and tests
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    initial begin
        #6000000;
        mismatches++;
        give_verdict();
    end
    initial begin
        {i_resetn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, stuck, byp, aut} = '0;
        mismatches = 0;
        compares = 0;
        void'($urandom(32'h6a65));
        repeat (16) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(negedge i_clock);
        check({ce_n, we_n, oe_n, dq_oe}, 4'b1110);
        apb(1'b0, fwsr_pkg::REG_STATUS, '0);
        check(r[fwsr_pkg::ST_READY], 1'b1);
        $display("test reset done");
        // Bit 7 both ways first, then random words
        for (int i = 0; i < 6; i++) begin
            fa = (i < 2) ? 21'h000040 : 21'($urandom & 32'hff);
            wd = (i == 0) ? 16'h0080 : (i == 1) ? 16'hff7f : 16'($urandom);
            apb(1'b1, fwsr_pkg::REG_ADDR, 32'(fa));
            apb(1'b1, fwsr_pkg::REG_WDATA, 32'(wd));
            run(4'h3);
            apb(1'b0, fwsr_pkg::REG_RDATA, '0);
            check(r, 32'(wd));
            run(4'h0);
            apb(1'b0, fwsr_pkg::REG_RDATA, '0);
            check(r, 32'(wd));
        end
        $display("test program done");
        // Protected sector, sector-protect query address
        apb(1'b1, fwsr_pkg::REG_ADDR, 32'h001ff002);
        foreach (ops[i]) begin
            e = refused(ops[i]);
            run(ops[i]);
            if (!e && ops[i] == 4'h4) byp = 1'b1;
            if (!e && ops[i] == 4'h6) byp = 1'b0;
            if (!e && ops[i] == 4'h2) aut = 1'b1;
            if (!e && ops[i] == 4'h1) aut = 1'b0;
            check(r[fwsr_pkg::ST_REFUSED], e);
            check(r[fwsr_pkg::ST_BYPASS], byp);
            check(r[fwsr_pkg::ST_AUTOSEL], aut);
            if (ops[i] == 4'h2) begin
                apb(1'b0, fwsr_pkg::REG_RDATA, '0);
                check(r, 32'h1);
            end
        end
        $display("test commands done");
        stuck <= 1'b1;
        run(4'h3);
        check(r[fwsr_pkg::ST_FAIL], 1'b1);
        check(r[fwsr_pkg::ST_READY], 1'b1);
        stuck <= 1'b0;
        $display("test timeout done");
        apb(1'b0, 8'h20, '0);
        check({err, r}, {1'b1, 32'h0});
        $display("test unmapped done");
        give_verdict();
    end
endmodule // tb
